/* core/nvrtc_pkg.sv */
// nvrtc_pkg: shared constants and carrier types for the timekeeping RAM
package nvrtc_pkg;
   // ****************************************************************
   // address map
   // ****************************************************************
   localparam int          NVRTC_ADDR_W    = 19;  // byte address width
   localparam logic [18:0] NVRTC_CENTURY_A = 19'h7_FFF8;
   localparam logic [18:0] NVRTC_SECONDS_A = 19'h7_FFF9;
   localparam logic [18:0] NVRTC_MINUTES_A = 19'h7_FFFA;
   localparam logic [18:0] NVRTC_HOURS_A   = 19'h7_FFFB;
   localparam logic [18:0] NVRTC_WEEKDAY_A = 19'h7_FFFC;
   localparam logic [18:0] NVRTC_MDAY_A    = 19'h7_FFFD;
   localparam logic [18:0] NVRTC_MONTH_A   = 19'h7_FFFE;
   localparam logic [18:0] NVRTC_YEAR_A    = 19'h7_FFFF;
   localparam logic [15:0] NVRTC_CLK_PAGE  = 16'hFFFF; // addr[18:3]
   // ****************************************************************
   // field positions
   // ****************************************************************
   localparam int NVRTC_WRITE_HOLD_B = 7;   // century bit 7
   localparam int NVRTC_READ_HOLD_B  = 6;   // century bit 6
   localparam int NVRTC_OSC_STOP_B   = 7;   // seconds bit 7
   localparam int NVRTC_BATT_B       = 7;   // weekday bit 7
   localparam int NVRTC_FTEST_B      = 6;   // weekday bit 6
   // ****************************************************************
   // timing, in ns and derived cycles at 25 MHz
   // ****************************************************************
   localparam int NVRTC_CLK_NS      = 40;
   localparam int NVRTC_READ_REL_NS = 500_000;  // read hold low, least
   localparam int NVRTC_READ_REL_CY =
      (NVRTC_READ_REL_NS + NVRTC_CLK_NS - 1) / NVRTC_CLK_NS;
   localparam int NVRTC_TICK_HZ     = 1024;     // half period of 512 Hz
   localparam int NVRTC_CLK_HZ      = 25_000_000;
   localparam int NVRTC_TICK_CY     = NVRTC_CLK_HZ / NVRTC_TICK_HZ;
   localparam int NVRTC_SEC_TICKS   = 1024;     // ticks per second
   // ****************************************************************
   // carrier for the eight clock bytes
   // ****************************************************************
   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] mday;
      logic [7:0] wday;
      logic [7:0] hours;
      logic [7:0] minutes;
      logic [7:0] seconds;
      logic [7:0] century;
   } nvrtc_time_type;
   // access modes of the strobe decode
   typedef enum logic [1:0] {
      NVRTC_IDLE  = 2'b00,
      NVRTC_READ  = 2'b01,
      NVRTC_WRITE = 2'b10
   } nvrtc_mode_type;
endpackage

/* core/nvrtc_top.sv */
// nvrtc_top: byte-wide NV SRAM with BCD clock registers in the top page
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RQ1 - top byte holds BCD year 00-99
// RQ2 - century: write hold, read hold, BCD 00-39
// RQ3 - seconds: oscillator stop bit, BCD 00-59
// RQ4 - day: battery flag, freq test, weekday
// RQ5 - minutes hours date month BCD counters
// RQ6 - spare clock bits are plain storage
// RQ7 - read when select, output enabled, no write
// RQ8 - data valid after access time
// RQ9 - old data held briefly on address change
// RQ10 - write while select and write both low
// RQ11 - host keeps address, recovery between cycles
// RQ12 - host meets data setup and hold
// RQ13 - write enable releases data bus
// RQ14 - host avoids contention during writes
// RQ15 - no access below power fail threshold
// RQ16 - open drain reset low during power fail
// RQ17 - battery flag read only, one if good
// RQ18 - read hold freezes visible time registers
// RQ19 - write hold loads counters on release
// RQ20 - oscillator stop halts all counting
// RQ21 - frequency test toggles seconds bit0 512 Hz
// RQ22 - power fail input gates bus access
// RQ23 - calendar rollover with leap years
module nvrtc_top
   import nvrtc_pkg::*;
#(
   parameter int MEM_DEPTH    = 524288,          // bytes of storage
   parameter int TICK_CY      = NVRTC_TICK_CY,   // cycles per 1024 Hz tick
   parameter int READ_REL_CY  = NVRTC_READ_REL_CY // read hold release wait
) (
   input  wire logic        clk_sys,        // 25 MHz system clock
   input  wire logic        reset,          // sync, active high
   input  wire logic        chip_en_n,      // chip select, low active
   input  wire logic        out_en_n,       // output enable, low active
   input  wire logic        write_en_n,     // write enable, low active
   input  wire logic [18:0] addr,           // byte address
   input  wire logic [7:0]  data_in,        // data pins, input side
   output logic      [7:0]  data_out,       // data pins, output side
   output logic             data_oe,        // high while driving data
   input  wire logic        power_fail,     // supply below threshold
   input  wire logic        battery_good,   // battery monitor level
   output logic             reset_out_oe    // open drain reset, drive low
);
   // checks below share the system clock and sit out reset
   default clocking cb_chk @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   // ****************************************************************
   // helpers
   // ****************************************************************
   // bcd increment with wrap to a given low value at a given limit
   function automatic logic [7:0] bcd_inc(input logic [7:0] v,
                                          input logic [7:0] lim,
                                          input logic [7:0] low);
      logic [7:0] r;
      r = v;
      if (v >= lim) begin
         r = low;
      end else if (v[3:0] == 4'h9) begin
         r = {v[7:4] + 4'h1, 4'h0};
      end else begin
         r = {v[7:4], v[3:0] + 4'h1};
      end
      return r;
   endfunction

   // last BCD date of a month, leap every fourth year
   function automatic logic [7:0] month_end(input logic [7:0] mon,
                                            input logic [7:0] yr);
      logic [7:0] r;
      logic       leap;
      r    = 8'h31;
      leap = (yr[4] ? (yr[1:0] == 2'b10) : (yr[1:0] == 2'b00));
      unique case (mon)
         8'h02: r = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
         default: r = 8'h31;
      endcase
      return r;
   endfunction

   // ****************************************************************
   // storage and state
   // ****************************************************************
   logic [7:0]     mem [MEM_DEPTH];       // user RAM bytes
   nvrtc_time_type cnt_r;                 // running counters
   nvrtc_time_type vis_r;                 // host visible copy
   logic [$clog2(TICK_CY)-1:0] div_r;     // 1024 Hz divider
   logic           tick_r;                // one cycle tick pulse
   logic [9:0]     sub_r;                 // ticks within a second
   logic           ftog_r;                // 512 Hz toggle level
   logic [$clog2(READ_REL_CY+1)-1:0] rel_r; // read hold low counter
   logic           wr_prev_r;             // ram write active last cycle
   logic [18:0]    wr_addr_r;             // address of live write
   logic [7:0]     wr_data_r;             // data of live write
   nvrtc_mode_type mode;                  // decoded strobe mode
   logic           is_clk;                // address hits clock page
   logic [2:0]     idx;                   // clock register index
   logic [7:0]     clk_q;                 // clock read value
   logic           halt;                  // visible copy frozen

   // strobe decode, blocked by power fail
   always_comb begin
      mode = NVRTC_IDLE;
      // RQ15 power fail blocks access
      // RQ22 input gates access at once
      if (!power_fail && !chip_en_n) begin
         // RQ10 write while both low
         if (!write_en_n) begin
            mode = NVRTC_WRITE;
         // RQ7 read decode
         end else if (!out_en_n) begin
            mode = NVRTC_READ;
         end
      end
   end

   assign is_clk = (addr[18:3] == NVRTC_CLK_PAGE);
   assign idx    = addr[2:0];
   assign halt   = vis_r.century[NVRTC_WRITE_HOLD_B] |
                   vis_r.century[NVRTC_READ_HOLD_B];

   // ****************************************************************
   // time base
   // ****************************************************************
   // divider to 1024 Hz, frozen while the oscillator is stopped
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         div_r  <= '0;
         tick_r <= 1'b0;
      // RQ20 oscillator stop halts base
      end else if (vis_r.seconds[NVRTC_OSC_STOP_B]) begin
         tick_r <= 1'b0;
      end else if (div_r == $bits(div_r)'(TICK_CY - 1)) begin
         div_r  <= '0;
         tick_r <= 1'b1;
      end else begin
         div_r  <= div_r + 1'b1;
         tick_r <= 1'b0;
      end
   end

   // 512 Hz level for the frequency test
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ftog_r <= 1'b0;
      end else if (tick_r) begin
         ftog_r <= ~ftog_r;
      end
   end

   // ****************************************************************
   // running counters
   // ****************************************************************
   // write hold release loads counters, else count seconds
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cnt_r <= '0;
         sub_r <= '0;
      // RQ19 load counters on release
      end else if (cnt_r.century[NVRTC_WRITE_HOLD_B] &
                   ~vis_r.century[NVRTC_WRITE_HOLD_B]) begin
         cnt_r <= vis_r;
         sub_r <= '0;
      end else if (vis_r.century[NVRTC_WRITE_HOLD_B]) begin
         // counters wait while the host sets the time
         cnt_r.century[NVRTC_WRITE_HOLD_B] <= 1'b1;
      end else if (tick_r) begin
         sub_r <= sub_r + 1'b1;
         if (sub_r == 10'(NVRTC_SEC_TICKS - 1)) begin
            // RQ23 rollover chain with leap
            cnt_r.seconds[6:0] <= 7'(bcd_inc({1'b0,
               cnt_r.seconds[6:0]}, 8'h59, 8'h00));
            if (cnt_r.seconds[6:0] == 7'h59) begin
               cnt_r.minutes[6:0] <= 7'(bcd_inc({1'b0,
                  cnt_r.minutes[6:0]}, 8'h59, 8'h00));
               if (cnt_r.minutes[6:0] == 7'h59) begin
                  cnt_r.hours[5:0] <= 6'(bcd_inc({2'b00,
                     cnt_r.hours[5:0]}, 8'h23, 8'h00));
                  if (cnt_r.hours[5:0] == 6'h23) begin
                     cnt_r.wday[2:0] <= (cnt_r.wday[2:0] >= 3'h7) ?
                                        3'h1 : cnt_r.wday[2:0] + 3'h1;
                     cnt_r.mday[5:0] <= 6'(bcd_inc({2'b00,
                        cnt_r.mday[5:0]}, month_end(
                        {3'b000, cnt_r.month[4:0]}, cnt_r.year),
                        8'h01));
                     if ({2'b00, cnt_r.mday[5:0]} >= month_end(
                         {3'b000, cnt_r.month[4:0]}, cnt_r.year)) begin
                        cnt_r.month[4:0] <= 5'(bcd_inc({3'b000,
                           cnt_r.month[4:0]}, 8'h12, 8'h01));
                        if (cnt_r.month[4:0] == 5'h12) begin
                           cnt_r.year <= bcd_inc(cnt_r.year,
                                                 8'h99, 8'h00);
                           if (cnt_r.year == 8'h99) begin
                              cnt_r.century[5:0] <= 6'(bcd_inc(
                                 {2'b00, cnt_r.century[5:0]},
                                 8'h39, 8'h00));
                           end
                        end
                     end
                  end
               end
            end
         end
      end
   end

   // read hold release timer, counts while read bit stays low
   always_ff @(posedge clk_sys) begin
      if (reset || vis_r.century[NVRTC_READ_HOLD_B]) begin
         rel_r <= '0;
      end else if (rel_r != $bits(rel_r)'(READ_REL_CY)) begin
         rel_r <= rel_r + 1'b1;
      end
   end

   // ****************************************************************
   // visible registers
   // ****************************************************************
   // host writes, else copy counters unless frozen
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         vis_r <= '0;
      end else if (mode == NVRTC_WRITE && is_clk) begin
         // RQ6 spare bits stored as written
         unique case (idx)
            3'd0: vis_r.century <= data_in;     // RQ2 hold bits
            3'd1: vis_r.seconds <= data_in;     // RQ3 stop bit
            3'd2: vis_r.minutes <= data_in;     // RQ5 counters
            3'd3: vis_r.hours   <= data_in;
            3'd4: vis_r.wday    <= data_in;     // RQ4 ftest, weekday
            3'd5: vis_r.mday    <= data_in;
            3'd6: vis_r.month   <= data_in;
            3'd7: vis_r.year    <= data_in;     // RQ1 year byte
         endcase
      // RQ18 frozen while held, update together
      // skip the load edge, the counters are stale until then
      end else if (!halt && !cnt_r.century[NVRTC_WRITE_HOLD_B] &&
                   rel_r == $bits(rel_r)'(READ_REL_CY)) begin
         vis_r.seconds[6:0] <= cnt_r.seconds[6:0];
         vis_r.minutes[6:0] <= cnt_r.minutes[6:0];
         vis_r.hours[5:0]   <= cnt_r.hours[5:0];
         vis_r.wday[2:0]    <= cnt_r.wday[2:0];
         vis_r.mday[5:0]    <= cnt_r.mday[5:0];
         vis_r.month[4:0]   <= cnt_r.month[4:0];
         vis_r.year         <= cnt_r.year;
         vis_r.century[5:0] <= cnt_r.century[5:0];
      end
   end

   // clock read mux with battery flag and frequency test
   always_comb begin
      clk_q = vis_r[idx*8 +: 8];
      if (idx == 3'd4) begin
         // RQ17 flag read only
         clk_q[NVRTC_BATT_B] = battery_good;
      end
      if (idx == 3'd1 && vis_r.wday[NVRTC_FTEST_B] &&
          !vis_r.seconds[NVRTC_OSC_STOP_B]) begin
         // RQ21 bit0 toggles at 512 Hz
         clk_q[0] = ftog_r;
      end
   end

   // ****************************************************************
   // RAM and data pins
   // ****************************************************************
   // RAM write commits on every clock edge of the write strobe
   always_ff @(posedge clk_sys) begin
      if (mode == NVRTC_WRITE && !is_clk) begin
         mem[addr] <= data_in;
      end
   end

   // last ram write, replayed by the write check
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wr_prev_r <= 1'b0;
         wr_addr_r <= '0;
         wr_data_r <= '0;
      end else begin
         wr_prev_r <= (mode == NVRTC_WRITE && !is_clk);
         wr_addr_r <= addr;
         wr_data_r <= data_in;
      end
   end

   // data pins: registered, one cycle of access latency
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         data_oe  <= 1'b0;
         data_out <= '0;
      end else begin
         // RQ13 write releases bus
         // RQ8 valid one cycle after stable
         data_oe  <= (mode == NVRTC_READ);
         // RQ9 old data held one cycle
         data_out <= is_clk ? clk_q : mem[addr];
      end
   end

   // power fail reset: open drain, drive low only
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reset_out_oe <= 1'b0;
      end else begin
         // RQ16 reset low while power fails
         reset_out_oe <= power_fail;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   // read strobes turn the drivers on next cycle
   a_read_drive: assert property ( // RQ7
      (!chip_en_n && !out_en_n && write_en_n && !power_fail)
      |=> data_oe) else $error("read not driven");
   // any write strobe keeps the drivers off
   a_write_float: assert property ( // RQ13
      !write_en_n |=> !data_oe) else $error("bus held in write");
   a_pf_block: assert property ( // RQ15
      power_fail |=> !data_oe && reset_out_oe)
      else $error("access during power fail");
   a_pf_reset: assert property ( // RQ16
      $fell(power_fail) |=> !reset_out_oe)
      else $error("reset held after power good");
   a_batt_flag: assert property ( // RQ17
      (idx == 3'd4 && is_clk && mode == NVRTC_READ)
      |=> data_out[NVRTC_BATT_B] == $past(battery_good))
      else $error("battery flag wrong");
   // read hold seen on two edges in a row
   sequence s_hold_set;
      vis_r.century[NVRTC_READ_HOLD_B] ##1
      vis_r.century[NVRTC_READ_HOLD_B];
   endsequence
   a_read_freeze: assert property ( // RQ18
      s_hold_set |-> $stable(vis_r.seconds[6:0]) ||
      $past(mode) == NVRTC_WRITE) else $error("frozen time moved");
   a_osc_stop: assert property ( // RQ20
      vis_r.seconds[NVRTC_OSC_STOP_B] |=> !tick_r)
      else $error("tick while stopped");
   a_wr_load: assert property ( // RQ19
      $fell(vis_r.century[NVRTC_WRITE_HOLD_B]) && !$past(reset)
      |=> cnt_r.minutes == $past(vis_r.minutes))
      else $error("counters not loaded");
   a_clk_write: assert property ( // RQ6
      (mode == NVRTC_WRITE && is_clk && idx == 3'd2)
      |=> vis_r.minutes == $past(data_in))
      else $error("clock write lost");
   // a ram byte must read back what the strobe carried
   a_ram_write: assert property ( // RQ10
      wr_prev_r |-> mem[wr_addr_r] == wr_data_r)
      else $error("ram write lost");

endmodule
`default_nettype wire

/* verif/nvrtc_host_model.sv */
// nvrtc_host_model: bus master model that drives the strobe pins
`timescale 1ns/1ps
`default_nettype none
module nvrtc_host_model (
   input  wire logic        clk_sys,    // system clock
   output logic             chip_en_n,  // select, low active
   output logic             out_en_n,   // output enable, low active
   output logic             write_en_n, // write enable, low active
   output logic      [18:0] addr,       // byte address
   output logic      [7:0]  data_in,    // write data
   input  wire logic [7:0]  data_out,   // read data
   input  wire logic        data_oe     // device drives data
);
   // idle bus at time zero
   initial begin
      chip_en_n  = 1'b1;
      out_en_n   = 1'b1;
      write_en_n = 1'b1;
      addr       = 19'h0_0000;
      data_in    = 8'h00;
   end
   // one byte write; keep_oe puts a read cycle ahead of the strobe
   task automatic wr(input logic [18:0] a, input logic [7:0] d,
                     input logic keep_oe, output logic oe_seen);
      @(posedge clk_sys);
      // data valid for the whole strobe
      addr       <= a;
      data_in    <= d;
      chip_en_n  <= 1'b0;
      // output enable stays high unless asked
      out_en_n   <= !keep_oe;
      write_en_n <= keep_oe;
      if (keep_oe) begin
         @(posedge clk_sys);
         write_en_n <= 1'b0;
      end
      @(posedge clk_sys);
      // address held to strobe end, then a recovery cycle
      chip_en_n  <= 1'b1;
      write_en_n <= 1'b1;
      out_en_n   <= 1'b1;
      data_in    <= ~d;   // released: never leave the stale byte
      @(posedge clk_sys);
      oe_seen = data_oe;
   endtask
   // one byte read, sampled one cycle after the request is taken
   task automatic rd(input logic [18:0] a, output logic [7:0] d,
                     output logic oe_seen);
      @(posedge clk_sys);
      addr      <= a;
      chip_en_n <= 1'b0;
      out_en_n  <= 1'b0;
      repeat (2) @(posedge clk_sys);
      d       = data_out;
      oe_seen = data_oe;
      chip_en_n <= 1'b1;
      out_en_n  <= 1'b1;
      @(posedge clk_sys);
   endtask
   // sustained read, counting changes of data bit 0
   task automatic watch(input logic [18:0] a, input int n,
                        output int flips);
      logic last;
      flips = 0;
      @(posedge clk_sys);
      addr      <= a;
      chip_en_n <= 1'b0;
      out_en_n  <= 1'b0;
      repeat (2) @(posedge clk_sys);
      last = data_out[0];
      repeat (n) begin
         @(posedge clk_sys);
         if (data_out[0] !== last) flips++;
         last = data_out[0];
      end
      chip_en_n <= 1'b1;
      out_en_n  <= 1'b1;
      @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
// tb: self-checking bench for the timekeeping RAM
`timescale 1ns/1ps
`default_nettype none
module tb;
   import nvrtc_pkg::*;
   // ****************************************************************
   // shortened counts so a second lasts 4096 cycles
   // ****************************************************************
   localparam int TICK  = 4;
   localparam int REL   = 4;
   localparam int SEC   = TICK * NVRTC_SEC_TICKS;
   localparam int LIMIT = 60000;  // about twice the expected run
   logic        clk_sys;       // system clock
   logic        reset;         // sync reset
   logic        chip_en_n;     // host select
   logic        out_en_n;      // host output enable
   logic        write_en_n;    // host write enable
   logic [18:0] addr;          // host address
   logic [7:0]  data_in;       // host write data
   logic [7:0]  data_out;      // device read data
   logic        data_oe;       // device drives data
   logic        power_fail;    // supply low
   logic        battery_good;  // battery monitor
   logic        reset_out_oe;  // reset pin pulled low
   int          mismatches;    // failed compares
   int          checks;        // compares made
   int          cycles;        // timeout counter
   nvrtc_top #(.TICK_CY(TICK), .READ_REL_CY(REL)) u_nvrtc_top (
      .clk_sys(clk_sys), .reset(reset), .chip_en_n(chip_en_n),
      .out_en_n(out_en_n), .write_en_n(write_en_n), .addr(addr),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .power_fail(power_fail), .battery_good(battery_good),
      .reset_out_oe(reset_out_oe));
   nvrtc_host_model u_nvrtc_host_model (
      .clk_sys(clk_sys), .chip_en_n(chip_en_n), .out_en_n(out_en_n),
      .write_en_n(write_en_n), .addr(addr), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe));
   // ****************************************************************
   // clock, timeout and shared helpers
   // ****************************************************************
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // hang guard: counts as a mismatch
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == LIMIT) begin
         mismatches++;
         complete_run();
      end
   end
   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic put(input logic [18:0] a, input logic [7:0] d);
      logic oe;
      u_nvrtc_host_model.wr(a, d, 1'b0, oe);
   endtask
   task automatic get(input logic [18:0] a, output logic [7:0] d);
      logic oe;
      u_nvrtc_host_model.rd(a, d, oe);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   // ram at both ends, then a write with output enable held low
   task automatic t_ram();
      logic [7:0] d;
      logic       oe;
      put(19'h0_0000, 8'h5A);
      put(19'h7_FFF7, 8'hC3);
      put(19'h0_0005, 8'hA5);
      get(19'h0_0000, d); chk("ram 0", 8'h5A, d);
      get(19'h7_FFF7, d); chk("ram top", 8'hC3, d);
      u_nvrtc_host_model.wr(19'h0_0010, 8'h66, 1'b1, oe);
      chk("oe in write", 8'h00, {7'h00, oe});
      get(19'h0_0010, d); chk("ram oe low", 8'h66, d);
   endtask
   // load 23:59:59 on a leap February 28th, let it roll over
   task automatic t_setclock();
      logic [7:0] d;
      put(NVRTC_CENTURY_A, 8'hA0);
      put(NVRTC_MONTH_A, 8'hE5);
      get(NVRTC_MONTH_A, d); chk("spare bits", 8'hE5, d);
      put(NVRTC_SECONDS_A, 8'h59);
      put(NVRTC_MINUTES_A, 8'h59);
      put(NVRTC_HOURS_A, 8'h23);
      put(NVRTC_WEEKDAY_A, 8'h07);
      put(NVRTC_MDAY_A, 8'h28);
      put(NVRTC_MONTH_A, 8'h02);
      put(NVRTC_YEAR_A, 8'h24);
      get(NVRTC_WEEKDAY_A, d); chk("weekday held", 8'h87, d);
      put(NVRTC_CENTURY_A, 8'h20);
      repeat (SEC * 3 / 2) @(posedge clk_sys);
      get(NVRTC_SECONDS_A, d);
      chk("seconds", 8'h00, {d[7:1], 1'b0});
      get(NVRTC_MINUTES_A, d); chk("minutes", 8'h00, d);
      get(NVRTC_HOURS_A, d); chk("hours", 8'h00, d);
      get(NVRTC_MDAY_A, d); chk("leap day", 8'h29, d);
      get(NVRTC_MONTH_A, d); chk("month", 8'h02, d);
      get(NVRTC_WEEKDAY_A, d); chk("weekday", 8'h81, d);
      get(NVRTC_YEAR_A, d); chk("year", 8'h24, d);
      get(NVRTC_CENTURY_A, d); chk("century", 8'h20, d);
   endtask
   // visible copy frozen under read hold, refreshed after release
   task automatic t_read_hold();
      logic [7:0] s1;
      logic [7:0] s2;
      put(NVRTC_CENTURY_A, 8'h60);
      // hold lands in second 00, the late read in second 03
      get(NVRTC_SECONDS_A, s1); chk("held", 8'h00, s1);
      repeat (2 * SEC) @(posedge clk_sys);
      get(NVRTC_SECONDS_A, s2); chk("frozen", 8'h00, s2);
      put(NVRTC_CENTURY_A, 8'h20);
      repeat (SEC + REL + 8) @(posedge clk_sys);
      get(NVRTC_SECONDS_A, s2); chk("refreshed", 8'h03, s2);
   endtask
   // frequency test then oscillator stop and restart
   task automatic t_osc();
      logic [7:0] d;
      int         flips;
      put(NVRTC_WEEKDAY_A, 8'h41);
      u_nvrtc_host_model.watch(NVRTC_SECONDS_A, 40, flips);
      // one toggle per tick of TICK cycles
      chk("ft toggles", 8'h01, {7'h00, flips >= 9 && flips <= 11});
      put(NVRTC_WEEKDAY_A, 8'h01);
      put(NVRTC_CENTURY_A, 8'hA0);
      put(NVRTC_SECONDS_A, 8'h90);
      put(NVRTC_CENTURY_A, 8'h20);
      repeat (2 * SEC) @(posedge clk_sys);
      get(NVRTC_SECONDS_A, d); chk("osc stopped", 8'h90, d);
      put(NVRTC_CENTURY_A, 8'hA0);
      put(NVRTC_SECONDS_A, 8'h10);
      put(NVRTC_CENTURY_A, 8'h20);
      repeat (SEC + 64) @(posedge clk_sys);
      get(NVRTC_SECONDS_A, d);
      chk("osc running", 8'h11, d);
   endtask
   // battery flag follows the monitor, then power fail blocks access
   task automatic t_power();
      logic [7:0] d;
      logic       oe;
      battery_good <= 1'b0;
      get(NVRTC_WEEKDAY_A, d); chk("battery low", 8'h01, d);
      battery_good <= 1'b1;
      @(posedge clk_sys);
      power_fail <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk("reset pin on", 8'h01, {7'h00, reset_out_oe});
      put(19'h0_0005, 8'h3C);
      u_nvrtc_host_model.rd(19'h0_0005, d, oe);
      chk("read blocked", 8'h00, {7'h00, oe});
      power_fail <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk("reset pin off", 8'h00, {7'h00, reset_out_oe});
      get(19'h0_0005, d); chk("write blocked", 8'hA5, d);
   endtask
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      reset        = 1'b1;
      power_fail   = 1'b0;
      battery_good = 1'b1;
      mismatches   = 0;
      checks       = 0;
      cycles       = 0;
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      t_ram();
      t_setclock();
      t_read_hold();
      t_osc();
      t_power();
      complete_run();
   end
endmodule
`default_nettype wire
